// *** verilog/drs_pkg.sv ***
// Purpose: Shared constants and types for the dedicated register set.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bit positions and map bounds are used by the core and its flag unit.
package drs_pkg;
  // Register widths
  localparam int WORD_W = 16;                              // Dedicated register width
  localparam int BYTE_W = 8;                               // Byte-wide data and flag width
  // Condition bits positions in the low byte of the status word
  localparam int CC_HALF   = 7;                            // Half carry
  localparam int CC_IEN    = 6;                            // Interrupt enable
  localparam int CC_LVL_HI = 5;                            // Interrupt level, upper bit
  localparam int CC_LVL_LO = 4;                            // Interrupt level, lower bit
  localparam int CC_NEG    = 3;                            // Negative
  localparam int CC_ZERO   = 2;                            // Zero
  localparam int CC_OVF    = 1;                            // Overflow
  localparam int CC_CARRY  = 0;                            // Carry
  // Flag vector order from the flag unit: {half, neg, zero, ovf, carry}
  localparam int FL_HALF  = 4;
  localparam int FL_NEG   = 3;
  localparam int FL_ZERO  = 2;
  localparam int FL_OVF   = 1;
  localparam int FL_CARRY = 0;
  // Reset value: bank 0, interrupts off, level 3 (levels 0 to 2 accepted once enabled)
  localparam logic [15:0] PSW_RESET = 16'h0030;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Register address generation for the general-purpose banks
  localparam logic [7:0] GPR_PAGE = 8'h01;                 // Address bits 15..8
  localparam int RAM_BYTES = 256;                          // On-chip RAM size
  localparam int BANK_DIV  = 16;                           // RAM bytes per usable bank count step
  localparam logic [5:0] NUM_BANKS = 6'(RAM_BYTES / BANK_DIV);
  // Unified 64 KB map bounds: I/O low, data above, program at top
  localparam logic [15:0] IO_LAST   = 16'h007F;
  localparam logic [15:0] DATA_LAST = 16'h027F;
  // Register selector for plain writes
  typedef enum logic [2:0] {
    SEL_IP, SEL_ACC, SEL_TMP, SEL_IDX, SEL_XP, SEL_STK, SEL_PSW
  } drs_sel_t;
  // Arithmetic and shift operations
  typedef enum logic [2:0] {
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_ROLC, OP_RORC, OP_PASS
  } drs_op_t;
endpackage

// *** verilog/drs_flag_unit.sv ***
// Purpose: Arithmetic result and condition flag generation.
// Assumes: Operands come from the accumulator pair on the same clock.
// Notes:   Purely combinational; byte mode looks at the low bytes only.
`timescale 1ns/1ps
module drs_flag_unit
  import drs_pkg::*;
(
  input  wire drs_op_t     op_in,       // Operation
  input  wire logic        word_in,     // High for 16-bit operation
  input  wire logic [15:0] a_in,        // Accumulator operand
  input  wire logic [15:0] b_in,        // Temporary accumulator operand
  input  wire logic        carry_in,    // Current carry flag
  output logic      [15:0] result_out,  // Operation result
  output logic      [4:0]  flags_out    // {half, neg, zero, ovf, carry}
);
  logic [16:0] wide;                    // Result with carry-out position
  logic [4:0]  nib;                     // Low nibble sum for half carry
  logic        sub;                     // Subtract family
  logic        cin;                     // Effective carry into bit 0
  logic        msb_a;                   // Operand sign bits
  logic        msb_b;
  logic        msb_r;
  logic [15:0] a_m;                     // Width-masked operands
  logic [15:0] b_m;

  ////////////////////////////////////////////////////////////////////////////
  // Adder, shifter and flags
  always_comb begin
    a_m   = word_in ? a_in : {8'h00, a_in[7:0]};
    b_m   = word_in ? b_in : {8'h00, b_in[7:0]};
    sub   = (op_in == OP_SUB) || (op_in == OP_SUBC);
    cin   = ((op_in == OP_ADDC) || (op_in == OP_SUBC)) ? carry_in : 1'b0;
    nib   = sub ? ({1'b0, a_m[3:0]} - {1'b0, b_m[3:0]} - {4'h0, cin})
                : ({1'b0, a_m[3:0]} + {1'b0, b_m[3:0]} + {4'h0, cin});
    wide  = sub ? ({1'b0, a_m} - {1'b0, b_m} - {16'h0000, cin})
                : ({1'b0, a_m} + {1'b0, b_m} + {16'h0000, cin});
    flags_out = 5'h00;
    // Carry out of the operand's top bit; a borrow shows as a one there
    flags_out[FL_CARRY] = word_in ? wide[16] : wide[8];
    flags_out[FL_HALF]  = nib[4];
    case (op_in)
      OP_ROLC: begin
        // Rotate through carry: carry takes the bit shifted out
        wide = {1'b0, a_m[14:0], carry_in};
        if (!word_in) begin
          wide[15:8] = 8'h00;
        end
        flags_out[FL_CARRY] = word_in ? a_m[15] : a_m[7];
        flags_out[FL_HALF]  = 1'b0;
      end
      OP_RORC: begin
        wide = word_in ? {1'b0, carry_in, a_m[15:1]} : {9'h000, carry_in, a_m[7:1]};
        flags_out[FL_CARRY] = a_m[0];
        flags_out[FL_HALF]  = 1'b0;
      end
      OP_PASS: begin
        // Transfer: flags follow the value only
        wide = {1'b0, a_m};
        flags_out[FL_CARRY] = 1'b0;
        flags_out[FL_HALF]  = 1'b0;
      end
      default: begin
        // Add and subtract already formed above
      end
    endcase
    result_out = wide[15:0];
    msb_a = word_in ? a_m[15] : a_m[7];
    msb_b = word_in ? b_m[15] : b_m[7];
    msb_r = word_in ? wide[15] : wide[7];
    flags_out[FL_NEG]  = msb_r;
    flags_out[FL_ZERO] = word_in ? (wide[15:0] == 16'h0000)
                                 : (wide[7:0] == 8'h00);
    // Two's complement overflow: sign of result disagrees with operands
    if (sub) begin
      flags_out[FL_OVF] = (msb_a != msb_b) && (msb_r != msb_a);
    end else if ((op_in == OP_ADD) || (op_in == OP_ADDC)) begin
      flags_out[FL_OVF] = (msb_a == msb_b) && (msb_r != msb_a);
    end else begin
      flags_out[FL_OVF] = 1'b0;
    end
  end
endmodule

// *** verilog/drs_core.sv ***
// Purpose: Dedicated register set of the 8-bit core with status word,
//          register bank addressing and unified memory map decode.
// Assumes: Sequencer and datapath drive all inputs on mclk_in.
// Notes:   Plain register writes override arithmetic results in a cycle.
//
// How it works
// - One unified 64 KB space, no others
// - I/O bottom, data above, program on top
// - 16-bit instruction pointer locates next fetch
// - 16-bit accumulator; byte ops touch low byte
// - 16-bit temporary accumulator is second operand
// - Index, extra pointer, stack pointer, 16 bits
// - Status word: bank select high, condition low
// - Register address: zeros, one, bank, opcode
// - Half carry from bit 3 into 4
// - Interrupt enable gates interrupts, reset clears
// - Accept only levels above current level
// - Negative follows result top bit
// - Zero set for zero result
// - Overflow on two's complement overflow
// - Carry out of bit 7 (bit 15 for word ops), shift-out
// - Eight 8-bit registers per RAM bank
// - Usable banks follow RAM size
`timescale 1ns/1ps
module drs_core
  import drs_pkg::*;
(
  // Clock, reset
  input  wire logic        mclk_in,                 // System clock
  input  wire logic        rst_in,                  // Synchronous reset

  // Register writes
  input  wire logic        wr_en_in,                // Plain register write
  input  wire drs_sel_t    wr_sel_in,               // Register to write
  input  wire logic [15:0] wr_data_in,              // Write data
  input  wire logic        byte_wr_in,              // Write low byte only (accumulator and temporary; other registers take all 16 bits)

  // Fetch, arithmetic
  input  wire logic        ip_step_in,              // Advance instruction pointer
  input  wire logic        alu_en_in,               // Load accumulator from unit
  input  wire drs_op_t     alu_op_in,               // Arithmetic operation
  input  wire logic        alu_word_in,             // 16-bit operation
  input  wire logic [4:0]  flag_mask_in,            // Flags defined by the op

  // Interrupt, address
  input  wire logic        irq_req_in,              // Pending interrupt
  input  wire logic [1:0]  irq_level_in,            // Its request level
  input  wire logic [2:0]  opc_low_in,              // Low opcode bits
  input  wire logic [15:0] mem_addr_in,             // Address to classify

  // Register views
  output logic      [15:0] instruction_pointer_out, // Fetch location
  output logic      [15:0] accumulator_out,         // Accumulator
  output logic      [15:0] temp_acc_out,            // Temporary accumulator
  output logic      [15:0] index_reg_out,           // Index register
  output logic      [15:0] extra_pointer_out,       // Extra pointer
  output logic      [15:0] stack_pointer_out,       // Stack pointer
  output logic      [15:0] program_status_word_out, // Whole status word

  // Status fields
  output logic      [4:0]  bank_select_out,         // Current bank
  output logic      [7:0]  condition_bits_out,      // Condition byte
  output logic             irq_enable_out,          // Interrupt enable flag
  output logic      [1:0]  irq_level_bits_out,      // Current level

  // Decoded outputs
  output logic      [15:0] gpr_addr_out,            // Register RAM address
  output logic             bank_valid_out,          // Bank exists in RAM
  output logic             irq_accept_out,          // Interrupt taken
  output logic             region_io_out,           // Address in I/O area
  output logic             region_data_out,         // Address in data area
  output logic             region_prog_out          // Address in program area
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] ip;      // Instruction pointer
    logic [15:0] acc;     // Accumulator
    logic [15:0] tmp;     // Temporary accumulator
    logic [15:0] idx;     // Index register
    logic [15:0] xp;      // Extra pointer
    logic [15:0] stk;     // Stack pointer
    logic [15:0] psw;     // Status word
  } drs_state_t;

  drs_state_t  st_q;      // Registered state
  drs_state_t  st_d;      // Next state

  logic [15:0] alu_res;   // Result from the flag unit
  logic [4:0]  alu_flags; // Flags from the flag unit

  // Memory area of an address; one and only one is set
  function automatic logic [2:0] area_of(input logic [15:0] addr);
    if (addr <= IO_LAST) begin
      area_of = 3'h1;
    end else if (addr <= DATA_LAST) begin
      area_of = 3'h2;
    end else begin
      area_of = 3'h4;
    end
  endfunction

  // Merge a write into a 16-bit register, low byte only when asked
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic        lo_only);
    merge = lo_only ? {old[15:8], val[7:0]} : val;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic and flags; accumulator with temporary as second operand
  drs_flag_unit u_flags (
    .op_in      (alu_op_in),
    .word_in    (alu_word_in),
    .a_in       (st_q.acc),
    .b_in       (st_q.tmp),
    .carry_in   (st_q.psw[CC_CARRY]),
    .result_out (alu_res),
    .flags_out  (alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    // All state holds unless asked
    st_d = st_q;

    // Sequential fetch; a plain write below takes precedence on a jump
    if (ip_step_in) begin
      st_d.ip = st_q.ip + 16'h0001;
    end

    // Arithmetic result; byte ops leave the high byte alone
    if (alu_en_in) begin
      st_d.acc = merge(st_q.acc, alu_res, !alu_word_in);
      // Only flags the op defines move; the rest hold
      if (flag_mask_in[FL_HALF]) begin
        st_d.psw[CC_HALF] = alu_flags[FL_HALF];
      end

      if (flag_mask_in[FL_NEG]) begin
        st_d.psw[CC_NEG] = alu_flags[FL_NEG];
      end

      if (flag_mask_in[FL_ZERO]) begin
        st_d.psw[CC_ZERO] = alu_flags[FL_ZERO];
      end

      if (flag_mask_in[FL_OVF]) begin
        st_d.psw[CC_OVF] = alu_flags[FL_OVF];
      end

      if (flag_mask_in[FL_CARRY]) begin
        st_d.psw[CC_CARRY] = alu_flags[FL_CARRY];
      end
    end

    // Plain writes from the sequencer
    if (wr_en_in) begin
      case (wr_sel_in)
        SEL_IP: begin
          st_d.ip = wr_data_in;
        end

        SEL_ACC: begin
          st_d.acc = merge(st_q.acc, wr_data_in, byte_wr_in);
        end

        SEL_TMP: begin
          st_d.tmp = merge(st_q.tmp, wr_data_in, byte_wr_in);
        end

        SEL_IDX: begin
          st_d.idx = wr_data_in;
        end

        SEL_XP: begin
          st_d.xp = wr_data_in;
        end

        SEL_STK: begin
          st_d.stk = wr_data_in;
        end

        SEL_PSW: begin
          // Bank and condition bytes change together, flags included
          st_d.psw = wr_data_in;
        end

        default: begin
          // Unused selector code writes nothing
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_q <= '{ip: REG_RESET, acc: REG_RESET, tmp: REG_RESET, idx: REG_RESET,
                 xp: REG_RESET, stk: REG_RESET, psw: PSW_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign instruction_pointer_out = st_q.ip;
  assign accumulator_out         = st_q.acc;
  assign temp_acc_out            = st_q.tmp;

  assign index_reg_out           = st_q.idx;
  assign extra_pointer_out       = st_q.xp;
  assign stack_pointer_out       = st_q.stk;

  assign program_status_word_out = st_q.psw;

  // Status word split into its two bytes
  assign bank_select_out         = st_q.psw[15:11];
  assign condition_bits_out      = st_q.psw[7:0];
  assign irq_enable_out          = st_q.psw[CC_IEN];
  assign irq_level_bits_out      = st_q.psw[CC_LVL_HI:CC_LVL_LO];

  // Eight byte registers per bank, picked by the low opcode bits
  assign gpr_addr_out = {GPR_PAGE, st_q.psw[15:11], opc_low_in};
  // Small RAM parts hold fewer banks; higher banks are not backed
  assign bank_valid_out = {1'b0, st_q.psw[15:11]} < NUM_BANKS;

  // Lower level value means higher priority; level 3 is never taken
  assign irq_accept_out = irq_req_in && st_q.psw[CC_IEN]
                          && (irq_level_in < st_q.psw[CC_LVL_HI:CC_LVL_LO]);

  // Unified map: every address falls in exactly one area
  assign {region_prog_out, region_data_out, region_io_out} = area_of(mem_addr_in);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  chk_ip_advance: assert property (
    ip_step_in
    && !(wr_en_in && wr_sel_in == SEL_IP)
    |=> instruction_pointer_out == $past(instruction_pointer_out) + 16'h0001)
    else $error("instruction pointer did not advance by one");

  chk_reg_address: assert property (
    gpr_addr_out[15:8] == GPR_PAGE
    && gpr_addr_out[7:3] == bank_select_out
    && gpr_addr_out[2:0] == opc_low_in)
    else $error("register address badly formed");

  chk_ien_reset: assert property (
    $fell(rst_in) |-> !irq_enable_out && irq_level_bits_out == 2'h3)
    else $error("interrupt enable not cleared by reset");

  chk_acc_byte_hold: assert property (
    alu_en_in && !alu_word_in
    && !wr_en_in
    |=> accumulator_out[15:8] == $past(accumulator_out[15:8]))
    else $error("byte operation changed accumulator high byte");

  chk_carry_hold: assert property (
    alu_en_in && !flag_mask_in[FL_CARRY] && !(wr_en_in && wr_sel_in == SEL_PSW)
    ##1 !alu_en_in && !wr_en_in
    |=> condition_bits_out[CC_CARRY] == $past(condition_bits_out[CC_CARRY], 2))
    else $error("undefined carry flag changed");

  chk_zero_flag: assert property (
    alu_en_in && flag_mask_in[FL_ZERO]
    && alu_word_in && !wr_en_in
    |=> condition_bits_out[CC_ZERO] == (accumulator_out == 16'h0000))
    else $error("zero flag disagrees with result");

  chk_irq_gate: assert property (
    irq_accept_out
    |-> irq_enable_out && irq_level_in != 2'h3
    && irq_level_in < irq_level_bits_out)
    else $error("interrupt accepted at or below current level");

  chk_psw_atomic: assert property (
    wr_en_in && wr_sel_in == SEL_PSW
    |=> program_status_word_out == $past(wr_data_in)
    && bank_select_out == $past(wr_data_in[15:11]))
    else $error("status word write not applied whole");

  chk_one_area: assert property (
    $onehot({region_prog_out, region_data_out, region_io_out})
    && (region_io_out == (mem_addr_in <= IO_LAST)))
    else $error("address not in exactly one area");

  chk_bank_limit: assert property (
    bank_valid_out == (bank_select_out < 5'(NUM_BANKS)))
    else $error("bank validity wrong");


  // Main scenarios reached
  cov_irq_taken: cover property (irq_req_in ##1 irq_accept_out);
  cov_carry_set: cover property (alu_en_in && flag_mask_in[FL_CARRY] ##1 condition_bits_out[CC_CARRY]);
  cov_psw_write: cover property (wr_en_in && wr_sel_in == SEL_PSW ##1 irq_enable_out);
  cov_bank_high: cover property (!bank_valid_out);
endmodule

// *** testbench/drs_seq_model.sv ***
// Purpose: Behavioural sequencer that issues requests to the register set.
// Assumes: Requests launch just after a rising edge and stand for one cycle.
// Notes:   Called from the bench; data lines are inverted once released.
`timescale 1ns/1ps
module drs_seq_model
  import drs_pkg::*;
(
  input  wire logic        mclk_in,        // System clock
  output logic             wr_en_out,      // Plain register write
  output drs_sel_t         wr_sel_out,     // Register to write
  output logic      [15:0] wr_data_out,    // Write data
  output logic             byte_wr_out,    // Low byte only (accumulator and temporary writes)
  output logic             ip_step_out,    // Advance fetch location
  output logic             alu_en_out,     // Load result into accumulator
  output drs_op_t          alu_op_out,     // Operation
  output logic             alu_word_out,   // 16-bit operation
  output logic      [4:0]  flag_mask_out,  // Flags the operation defines
  output logic             irq_req_out,    // Pending interrupt
  output logic      [1:0]  irq_level_out,  // Its level
  output logic      [2:0]  opc_low_out,    // Low opcode bits
  output logic      [15:0] mem_addr_out    // Address to classify
);
  ////////////////////////////////////////////////////////////////////////////
  // Quiet at time zero so nothing is requested during reset
  initial begin
    {wr_en_out, byte_wr_out, ip_step_out, alu_en_out, alu_word_out, irq_req_out} = 6'h00;
    wr_sel_out    = SEL_IP;
    alu_op_out    = OP_PASS;
    wr_data_out   = 16'h0000;
    flag_mask_out = 5'h00;
    irq_level_out = 2'h0;
    opc_low_out   = 3'h0;
    mem_addr_out  = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One request cycle; the strobes drop on the edge that takes it
  task automatic req(input logic wr, input drs_sel_t sel, input logic [15:0] data, input logic lo,
                     input logic step, input drs_op_t op, input logic alu, input logic word,
                     input logic [4:0] mask);
    @(posedge mclk_in);
    wr_en_out     <= wr;
    wr_sel_out    <= sel;
    wr_data_out   <= data;
    byte_wr_out   <= lo;
    ip_step_out   <= step;
    alu_op_out    <= op;
    alu_en_out    <= alu;
    alu_word_out  <= word;
    flag_mask_out <= mask;
    @(posedge mclk_in);
    wr_en_out     <= 1'b0;
    ip_step_out   <= 1'b0;
    alu_en_out    <= 1'b0;
    wr_data_out   <= ~data;  // Stale data must not look valid
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Present address, opcode and interrupt inputs; results are combinational
  task automatic probe(input logic [15:0] addr, input logic [2:0] opc, input logic irq,
                       input logic [1:0] lvl);
    @(posedge mclk_in);
    mem_addr_out  <= addr;
    opc_low_out   <= opc;
    irq_req_out   <= irq;
    irq_level_out <= lvl;
    #1;
  endtask
endmodule

// *** testbench/cpu_dedicated_register_set_test.sv ***
// Purpose: Self-checking bench for the dedicated register set.
// Assumes: The sequencer model launches every request; bench owns clock and reset.
// Notes:   Flag and map expectations are worked out by hand.
`timescale 1ns/1ps
module cpu_dedicated_register_set_test
  import drs_pkg::*;
;
  logic        mclk_in;                                          // 250 MHz clock
  logic        rst_in;                                           // Synchronous reset
  logic        wr_en, byte_wr, ip_step, alu_en, alu_word, irq_req; // Request strobes
  drs_sel_t    wr_sel;                                           // Register chosen
  drs_op_t     alu_op;                                           // Operation chosen
  logic [15:0] wr_data, mem_addr;                                // Data and probed address
  logic [4:0]  flag_mask, bank;                                  // Flag mask, bank view
  logic [2:0]  opc_low;                                          // Low opcode bits
  logic [1:0]  irq_level, lvl;                                   // Request and current level
  logic [15:0] ip, acc, tmp, idx, xp, stk, psw, gpr;             // Register views
  logic [7:0]  condition_bits;                                              // Condition byte
  logic        ien, bvalid, accept, r_io, r_data, r_prog;        // Single-bit views
  int          err_total = 0, num_checks = 0, cyc = 0;           // Tallies
  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a ceiling far above the roughly 150 cycles the run needs
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  drs_seq_model seq (.mclk_in(mclk_in), .wr_en_out(wr_en), .wr_sel_out(wr_sel), .wr_data_out(wr_data),
    .byte_wr_out(byte_wr), .ip_step_out(ip_step), .alu_en_out(alu_en), .alu_op_out(alu_op),
    .alu_word_out(alu_word), .flag_mask_out(flag_mask), .irq_req_out(irq_req),
    .irq_level_out(irq_level), .opc_low_out(opc_low), .mem_addr_out(mem_addr));
  drs_core DUT (.mclk_in(mclk_in), .rst_in(rst_in), .wr_en_in(wr_en), .wr_sel_in(wr_sel),
    .wr_data_in(wr_data), .byte_wr_in(byte_wr), .ip_step_in(ip_step), .alu_en_in(alu_en),
    .alu_op_in(alu_op), .alu_word_in(alu_word), .flag_mask_in(flag_mask), .irq_req_in(irq_req),
    .irq_level_in(irq_level), .opc_low_in(opc_low), .mem_addr_in(mem_addr),
    .instruction_pointer_out(ip), .accumulator_out(acc), .temp_acc_out(tmp), .index_reg_out(idx),
    .extra_pointer_out(xp), .stack_pointer_out(stk), .program_status_word_out(psw),
    .bank_select_out(bank), .condition_bits_out(condition_bits), .irq_enable_out(ien),
    .irq_level_bits_out(lvl), .gpr_addr_out(gpr), .bank_valid_out(bvalid), .irq_accept_out(accept),
    .region_io_out(r_io), .region_data_out(r_data), .region_prog_out(r_prog));
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input drs_sel_t sel, input logic [15:0] data, input logic lo);
    seq.req(1'b1, sel, data, lo, 1'b0, OP_PASS, 1'b0, 1'b0, 5'h00);
  endtask
  function automatic logic [15:0] view(input drs_sel_t sel);
    case (sel)
      SEL_IP:  return ip;
      SEL_ACC: return acc;
      SEL_TMP: return tmp;
      SEL_IDX: return idx;
      SEL_XP:  return xp;
      default: return stk;
    endcase
  endfunction
  // Load the accumulator, run one operation, compare result and condition byte
  task automatic alu_chk(input logic [15:0] a0, input drs_op_t op, input logic word,
                         input logic [4:0] mask, input logic [15:0] a1, input logic [7:0] cc);
    wr(SEL_ACC, a0, 1'b0);
    seq.req(1'b0, SEL_PSW, 16'h0000, 1'b0, 1'b0, op, 1'b1, word, mask);
    check("alu_acc", acc, a1);
    check("alu_ccr", 16'(condition_bits), 16'(cc));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      check("reg_reset", view(drs_sel_t'(i)), 16'h0000);
    end
    check("psw_reset", psw, 16'h0030);
    check("ien_reset", 16'(ien), 16'h0000);
  endtask
  task automatic t_writes();
    logic [15:0] d;
    for (int i = 0; i < 6; i++) begin
      d = {4'(i + 1), 12'hA5C};
      wr(drs_sel_t'(i), d, 1'b0);
      check("reg_write", view(drs_sel_t'(i)), d);
    end
    wr(SEL_ACC, 16'hFFFF, 1'b0);
    wr(SEL_ACC, 16'h0012, 1'b1);
    check("acc_byte", acc, 16'hFF12);
    wr(SEL_TMP, 16'hFFFF, 1'b0);
    wr(SEL_TMP, 16'h0034, 1'b1);
    check("tmp_byte", tmp, 16'hFF34);
    wr(SEL_IP, 16'hFFFF, 1'b0);
    seq.req(1'b0, SEL_IP, 16'h0000, 1'b0, 1'b1, OP_PASS, 1'b0, 1'b0, 5'h00);
    check("ip_wrap", ip, 16'h0000);
    seq.req(1'b1, SEL_IP, 16'h1234, 1'b0, 1'b1, OP_PASS, 1'b0, 1'b0, 5'h00);
    check("ip_write_wins", ip, 16'h1234);
  endtask
  task automatic t_bank();
    logic [15:0] p [4] = '{16'h0840, 16'h7800, 16'h8000, 16'hF8FF};
    logic [2:0]  o [4] = '{3'h5, 3'h7, 3'h0, 3'h7};
    logic [15:0] g [4] = '{16'h010D, 16'h017F, 16'h0180, 16'h01FF};
    for (int i = 0; i < 4; i++) begin
      wr(SEL_PSW, p[i], 1'b0);
      seq.probe(16'h0000, o[i], 1'b0, 2'h0);
      check("bank", 16'(bank), 16'(p[i][15:11]));
      check("ccr", 16'(condition_bits), 16'(p[i][7:0]));
      check("ien_lvl", 16'({ien, lvl}), 16'(p[i][6:4]));
      check("gpr_addr", gpr, g[i]);
      check("bank_valid", 16'(bvalid), 16'(i < 2));
    end
  endtask
  task automatic t_irq();
    logic exp;
    for (int l = 0; l < 4; l++) begin
      for (int e = 0; e < 2; e++) begin
        wr(SEL_PSW, {9'h000, e[0], l[1:0], 4'h0}, 1'b0);
        for (int r = 0; r < 4; r++) begin
          seq.probe(16'h0000, 3'h0, 1'b1, 2'(r));
          exp = (e == 1) && (r < l);
          check("irq_accept", 16'(accept), 16'(exp));
        end
      end
    end
    seq.probe(16'h0000, 3'h0, 1'b0, 2'h0);
    check("irq_idle", 16'(accept), 16'h0000);
  endtask
  task automatic t_region();
    logic [15:0] a [6] = '{16'h0000, 16'h007F, 16'h0080, 16'h027F, 16'h0280, 16'hFFFF};
    logic [2:0]  x [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
    for (int i = 0; i < 6; i++) begin
      seq.probe(a[i], 3'h0, 1'b0, 2'h0);
      check("region", 16'({r_io, r_data, r_prog}), 16'(x[i]));
    end
  endtask
  task automatic t_alu();
    wr(SEL_PSW, 16'h0000, 1'b0);
    wr(SEL_TMP, 16'h0001, 1'b0);
    alu_chk(16'h12FF, OP_ADD, 1'b0, 5'h1F, 16'h1200, 8'h85);
    alu_chk(16'h007F, OP_ADD, 1'b0, 5'h1F, 16'h0080, 8'h8A);
    alu_chk(16'h0000, OP_SUB, 1'b0, 5'h1F, 16'h00FF, 8'h89);
    alu_chk(16'h0002, OP_RORC, 1'b0, 5'h01, 16'h0081, 8'h88);
    alu_chk(16'h0081, OP_ADD, 1'b0, 5'h00, 16'h0082, 8'h88);
    alu_chk(16'h7FFF, OP_ADD, 1'b1, 5'h1F, 16'h8000, 8'h8A);
    alu_chk(16'h0081, OP_ROLC, 1'b0, 5'h01, 16'h0002, 8'h8B);
    alu_chk(16'h00FF, OP_ADDC, 1'b0, 5'h1F, 16'h0001, 8'h81);
    alu_chk(16'h0010, OP_SUBC, 1'b0, 5'h1F, 16'h000E, 8'h80);
    alu_chk(16'h8000, OP_PASS, 1'b1, 5'h1F, 16'h8000, 8'h08);
    check("tmp_kept", tmp, 16'h0001);
  endtask
  task automatic t_rereset();
    wr(SEL_PSW, 16'h0840, 1'b0);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    check("psw_rereset", psw, 16'h0030);
    check("acc_rereset", acc, 16'h0000);
    wr(SEL_IDX, 16'h00C3, 1'b0);
    check("idx_after_reset", idx, 16'h00C3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_in = 1'b1;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    t_reset();
    t_writes();
    t_bank();
    t_irq();
    t_region();
    t_alu();
    t_rereset();
    tally_and_finish();
  end
endmodule
